/* File: hdl/obc_pkg.sv */
// package for the option byte configuration decoder
package obc_pkg;
    // register byte addresses
    localparam logic [11:0] OPT_BYTE_ADDR   = 12'h000;
    localparam logic [11:0] STATUS_ADDR     = 12'h004;
    localparam logic [11:0] CTRL_ADDR       = 12'h008;
    // option byte field positions
    localparam int TIMEOUT_ACTION_BIT  = 7;
    localparam int WDOG_ALWAYS_ON_BIT  = 6;
    localparam int OSC_SEL_HI          = 5;
    localparam int OSC_SEL_LO          = 4;
    localparam int BROWNOUT_AO_BIT     = 3;
    localparam int READ_PROTECT_BIT    = 2;
    localparam int WRITE_PROTECT_BIT   = 0;
    // erased option byte value
    localparam logic [7:0] ERASED_VALUE = 8'hff;
    localparam logic [7:0] RESERVED_MASK = 8'h02;
    // control register fields
    localparam int CTRL_REFRESH_BIT  = 0;
    localparam int CTRL_STOP_BIT     = 1;
    localparam int CTRL_RECOVER_BIT  = 2;
    localparam int CTRL_TIMEOUT_BIT  = 3;
    localparam int CTRL_GIE_BIT      = 4;
    // status register fields
    localparam int ST_LOADED_BIT    = 0;
    localparam int ST_WDOG_RUN_BIT  = 1;
    localparam int ST_BROWNOUT_BIT  = 2;
    localparam int ST_STOP_BIT      = 3;
    localparam int ST_IRQ_BIT       = 4;
    localparam int ST_SRST_BIT      = 5;
    // unmapped read value
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // loader states
    typedef enum logic [1:0] {
        LD_IDLE  = 2'b00,
        LD_FETCH = 2'b01,
        LD_DONE  = 2'b10
    } obc_ld_state_t;
    // oscillator drive codes
    typedef enum logic [1:0] {
        OSC_RC     = 2'b00,
        OSC_LOW    = 2'b01,
        OSC_MEDIUM = 2'b10,
        OSC_HIGH   = 2'b11
    } obc_osc_t;
    // decoded option settings
    typedef struct packed {
        logic     timeout_action_select;
        logic     watchdog_always_on;
        obc_osc_t oscillator_drive_select;
        logic     brownout_always_on;
        logic     read_protect;
        logic     program_write_protect;
    } obc_opts_t;
endpackage

/* File: hdl/obc_top.sv */
// option byte configuration decoder with apb access
//
// Summary of operation
// RULE1: the option byte is fetched from program memory address zero and its bits are split into the six fields.
// RULE2: the stored option byte is never changed by reset and may be read and written through its register.
// RULE3: with the time-out action bit clear a watchdog time-out raises an interrupt, taken only with interrupts enabled.
// RULE4: with the time-out action bit set a watchdog time-out gives a short reset, the erased default.
// RULE5: with the always-on bit clear the watchdog runs from power-up and stops only in stop mode.
// RULE6: with the always-on bit set the watchdog starts on the refresh instruction and stops only on reset or stop recovery.
// RULE7: oscillator codes 00, 01 and 10 select rc, low-power and medium-power drive.
// RULE8: oscillator code 11 selects maximum-power drive, the erased default.
// RULE9: with the brownout bit clear brownout protection is off in stop mode.
// RULE10: with the brownout bit set brownout protection stays on in every mode.
// RULE11: with the read protect bit clear user code is made inaccessible from outside.
// RULE12: the option byte is latched during reset before the vector fetch and held stable afterwards; the code latches it on the first clock after reset ends.
`timescale 1ns/1ps
module obc_top (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             CPU_RUN,
    output logic             WDOG_RUN,
    output logic             WDOG_IRQ,
    output logic             SHORT_RESET,
    output logic [1:0]       OSC_DRIVE,
    output logic             BROWNOUT_EN,
    output logic             CODE_LOCKED,
    output logic             WRITE_PROTECTED
);
    function automatic obc_pkg::obc_opts_t decode_opts(input logic [7:0] b);
        obc_pkg::obc_opts_t o;
        o.timeout_action_select   = b[obc_pkg::TIMEOUT_ACTION_BIT];
        o.watchdog_always_on      = b[obc_pkg::WDOG_ALWAYS_ON_BIT];
        o.oscillator_drive_select = obc_pkg::obc_osc_t'(b[obc_pkg::OSC_SEL_HI:obc_pkg::OSC_SEL_LO]);
        o.brownout_always_on      = b[obc_pkg::BROWNOUT_AO_BIT];
        o.read_protect            = b[obc_pkg::READ_PROTECT_BIT];
        o.program_write_protect   = b[obc_pkg::WRITE_PROTECT_BIT];
        return o;
    endfunction

    // non-volatile cell, no reset branch
    logic [7:0]              nv_q;
    logic                    nv_init_q = 1'b0;
    obc_pkg::obc_ld_state_t  ld_q;
    logic [7:0]              latched_q;
    obc_pkg::obc_opts_t      opts;
    logic                    wr_acc;
    logic                    rd_acc;
    logic                    refresh_w;
    logic                    stop_w;
    logic                    recover_w;
    logic                    timeout_w;
    logic                    gie_q;
    logic                    stop_q;
    logic                    wdog_q;
    logic                    irq_q;
    logic                    srst_q;
    logic                    loaded;

    assign wr_acc    = PSEL & PENABLE & PWRITE;
    assign rd_acc    = PSEL & PENABLE & ~PWRITE;
    assign refresh_w = wr_acc && PADDR == obc_pkg::CTRL_ADDR && PWDATA[obc_pkg::CTRL_REFRESH_BIT];
    assign stop_w    = wr_acc && PADDR == obc_pkg::CTRL_ADDR && PWDATA[obc_pkg::CTRL_STOP_BIT];
    assign recover_w = wr_acc && PADDR == obc_pkg::CTRL_ADDR && PWDATA[obc_pkg::CTRL_RECOVER_BIT];
    assign timeout_w = wr_acc && PADDR == obc_pkg::CTRL_ADDR && PWDATA[obc_pkg::CTRL_TIMEOUT_BIT];
    assign loaded    = ld_q == obc_pkg::LD_DONE;
    assign opts      = decode_opts(latched_q);

    // program memory byte, erased on first clock, untouched by reset
    always_ff @(posedge MCLK) begin
        if (!nv_init_q) begin
            nv_q      <= obc_pkg::ERASED_VALUE;
            nv_init_q <= 1'b1;
        end else if (wr_acc && PADDR == obc_pkg::OPT_BYTE_ADDR) begin
            nv_q <= PWDATA[7:0] | obc_pkg::RESERVED_MASK; // [RULE2]
        end
    end

    // loader: fetch on the first clock after reset, release cpu after latch
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ld_q      <= obc_pkg::LD_FETCH;
            latched_q <= obc_pkg::ERASED_VALUE;
        end else begin
            case (ld_q)
                obc_pkg::LD_IDLE: begin
                    ld_q <= obc_pkg::LD_FETCH;
                end
                obc_pkg::LD_FETCH: begin
                    latched_q <= nv_q; // [RULE1] [RULE12]
                    ld_q      <= obc_pkg::LD_DONE;
                end
                default: begin
                    ld_q <= obc_pkg::LD_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            gie_q  <= 1'b0;
            stop_q <= 1'b0;
        end else if (wr_acc && PADDR == obc_pkg::CTRL_ADDR) begin
            gie_q  <= PWDATA[obc_pkg::CTRL_GIE_BIT];
            stop_q <= stop_w ? 1'b1 : (recover_w ? 1'b0 : stop_q);
        end
    end

    // watchdog run state
    always_ff @(posedge MCLK) begin
        if (RST || !loaded) begin
            wdog_q <= 1'b0;
        end else if (!opts.watchdog_always_on) begin
            wdog_q <= ~stop_q; // [RULE5]
        end else if (recover_w) begin
            wdog_q <= 1'b0; // [RULE6]
        end else if (refresh_w) begin
            wdog_q <= 1'b1; // [RULE6]
        end
    end

    // time-out action; set wins over acknowledge
    always_ff @(posedge MCLK) begin
        if (RST) begin
            irq_q  <= 1'b0;
            srst_q <= 1'b0;
        end else begin
            srst_q <= timeout_w && wdog_q && opts.timeout_action_select; // [RULE4]
            if (timeout_w && wdog_q && !opts.timeout_action_select) begin
                irq_q <= 1'b1; // [RULE3]
            end else if (refresh_w) begin
                irq_q <= 1'b0;
            end
        end
    end

    // apb read data and outputs
    always_ff @(posedge MCLK) begin
        if (RST) begin
            PRDATA <= obc_pkg::ZERO_WORD;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            if (PADDR == obc_pkg::OPT_BYTE_ADDR) begin
                PRDATA <= {24'h000000, nv_q}; // [RULE2]
            end else if (PADDR == obc_pkg::STATUS_ADDR) begin
                PRDATA <= {26'h0000000, srst_q, irq_q, stop_q, BROWNOUT_EN, wdog_q, loaded};
            end else if (PADDR == obc_pkg::CTRL_ADDR) begin
                PRDATA <= {27'h0000000, gie_q, 2'h0, stop_q, 1'b0};
            end else begin
                PRDATA <= obc_pkg::ZERO_WORD;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && PADDR != obc_pkg::OPT_BYTE_ADDR
                       && PADDR != obc_pkg::STATUS_ADDR && PADDR != obc_pkg::CTRL_ADDR;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            CPU_RUN         <= 1'b0;
            WDOG_RUN        <= 1'b0;
            WDOG_IRQ        <= 1'b0;
            SHORT_RESET     <= 1'b0;
            OSC_DRIVE       <= obc_pkg::OSC_HIGH;
            BROWNOUT_EN     <= 1'b1;
            CODE_LOCKED     <= 1'b0;
            WRITE_PROTECTED <= 1'b0;
        end else begin
            CPU_RUN         <= loaded; // [RULE12]
            WDOG_RUN        <= wdog_q;
            WDOG_IRQ        <= irq_q & gie_q; // [RULE3]
            SHORT_RESET     <= srst_q; // [RULE4]
            OSC_DRIVE       <= opts.oscillator_drive_select; // [RULE7] [RULE8]
            BROWNOUT_EN     <= opts.brownout_always_on | ~stop_q; // [RULE9] [RULE10]
            CODE_LOCKED     <= loaded & ~opts.read_protect; // [RULE11]
            WRITE_PROTECTED <= loaded & ~opts.program_write_protect;
        end
    end
endmodule

/* File: tb/obc_flash_model.sv */
// behavioural program memory word holding the option byte
`timescale 1ns/1ps
module obc_flash_model (
    input  wire logic       clk,
    input  wire logic       wr,
    input  wire logic [7:0] d,
    output logic      [7:0] img
);
    initial img = obc_pkg::ERASED_VALUE;
    // no reset input: contents survive every reset
    always @(posedge clk) begin
        if (wr) begin
            img <= d | obc_pkg::RESERVED_MASK;
        end
    end
endmodule

/* File: tb/obc_assertions.sv */
// port checker for the option byte decoder
`timescale 1ns/1ps
module obc_checker (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic       PREADY,
    input wire logic       PSLVERR,
    input wire logic       CPU_RUN,
    input wire logic       WDOG_IRQ,
    input wire logic       SHORT_RESET,
    input wire logic [1:0] OSC_DRIVE,
    input wire logic       BROWNOUT_EN,
    input wire logic       CODE_LOCKED,
    input wire logic       WRITE_PROTECTED
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
    a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("lone slverr");
    a_osc_in_reset: assert property (disable iff (1'b0) RST |=> OSC_DRIVE == 2'b11)
        else $error("osc drive not max in reset");
    a_bo_in_reset: assert property (disable iff (1'b0) RST |=> BROWNOUT_EN && !CPU_RUN)
        else $error("reset outputs wrong");
    a_cpu_start: assert property ($fell(RST) |-> ##[1:4] CPU_RUN) else $error("cpu not started");
    a_opts_stable: assert property (CPU_RUN && $past(CPU_RUN) |->
        $stable({OSC_DRIVE, CODE_LOCKED, WRITE_PROTECTED})) else $error("options moved");
    a_short_pulse: assert property (SHORT_RESET |=> !SHORT_RESET) else $error("long short reset");
    a_irq_not_srst: assert property (WDOG_IRQ |-> !SHORT_RESET) else $error("irq with reset");
endmodule
bind obc_top obc_checker obc_checker_inst (.*);

/* File: tb/option_byte_config_decoder_test.sv */
// register level test of the option byte decoder
`timescale 1ns/1ps
module option_byte_config_decoder_test;
    logic        MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, fw = 1'b0, err;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic        PREADY, PSLVERR, CPU_RUN, WDOG_RUN, WDOG_IRQ, SHORT_RESET, BROWNOUT_EN, CODE_LOCKED;
    logic        WRITE_PROTECTED;
    logic [1:0]  OSC_DRIVE;
    logic [7:0]  fd = 8'h00, img;
    int          errors = 0, total_checks = 0, srst_seen = 0;
    always @(posedge MCLK) if (SHORT_RESET === 1'b1) srst_seen++;
    initial forever #2.5 MCLK = ~MCLK;
    obc_top obc_top_inst (.*);
    obc_flash_model obc_flash_model_inst (.clk(MCLK), .wr(fw), .d(fd), .img(img));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            end_of_test();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task ctl(input logic [31:0] d);
        apb(1'b1, obc_pkg::CTRL_ADDR, d);
        repeat (3) @(posedge MCLK);
    endtask
    // reset, then compare decoded outputs with the stored image
    task boot;
        int n;
        RST <= 1'b1;
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (CPU_RUN !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            end_of_test();
        end
        @(posedge MCLK);
        chk(32'(OSC_DRIVE), 32'(img[5:4]));
        chk(32'(CODE_LOCKED), 32'(!img[2]));
        chk(32'(WRITE_PROTECTED), 32'(!img[0]));
        chk(32'(WDOG_RUN), 32'(!img[6]));
        chk(32'(BROWNOUT_EN), 32'h1);
        apb(1'b0, obc_pkg::OPT_BYTE_ADDR, 32'h0);
        chk(rd, {24'h0, img});
    endtask
    initial begin
        boot();
        ctl(32'h02);
        chk(32'(BROWNOUT_EN), 32'h1);
        ctl(32'h04);
        ctl(32'h01);
        chk(32'(WDOG_RUN), 32'h1);
        ctl(32'h18);
        chk(32'(WDOG_IRQ), 32'h0);
        chk(32'(srst_seen), 32'h1);
        for (int k = 0; k < 4; k++) begin
            fw <= 1'b1;
            fd <= {2'b00, k[1:0], 3'b000, k[0]};
            apb(1'b1, obc_pkg::OPT_BYTE_ADDR, {24'h0, 2'b00, k[1:0], 3'b000, k[0]});
            fw <= 1'b0;
            boot();
        end
        ctl(32'h12);
        chk(32'(BROWNOUT_EN), 32'h0);
        chk(32'(WDOG_RUN), 32'h0);
        apb(1'b0, obc_pkg::CTRL_ADDR, 32'h0);
        chk(rd, 32'h12);
        apb(1'b0, obc_pkg::STATUS_ADDR, 32'h0);
        chk(rd, 32'h09);
        ctl(32'h14);
        chk(32'(WDOG_RUN), 32'h1);
        ctl(32'h18);
        chk(32'(WDOG_IRQ), 32'h1);
        ctl(32'h01);
        chk(32'(WDOG_IRQ), 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        end_of_test();
    end
endmodule
